//--- design/adapter_desc_regs.vh
`ifndef ADAPTER_DESC_REGS_VH
`define ADAPTER_DESC_REGS_VH

// descriptor type codes and lengths
`define DT_ENDPOINT 8'h05
`define DT_INTERFACE 8'h04
`define DT_COMPANION 8'h11
`define LEN_ENDPOINT 8'h07
`define LEN_COMPANION 8'h0A
`define LEN_INTERFACE 8'h09

// descriptor selector codes
`define SEL_READ_EP 3'h0
`define SEL_READ_COMP 3'h1
`define SEL_ISO_IF 3'h2
`define SEL_ISO_OUT_EP 3'h3
`define SEL_ISO_OUT_COMP 3'h4
`define SEL_ISO_IN_EP 3'h5

// fixed field values
`define ATTR_BULK 8'h02
`define ATTR_BULK_ADJ_BIT 7
`define ATTR_ISO 8'h01
`define ATTR_DYN_SWITCH 8'h02
`define IF_NUMBER 8'h01
`define IF_ALT 8'h00
`define IF_CLASS 8'hE0
`define IF_SUBCLASS 8'h02
`define IF_PROTOCOL 8'h03
`define RESERVED_BYTE 8'h00

// field limits
`define SEQ_MIN 8'h02
`define SEQ_MAX 8'h20
`define NUM_EP_MIN 8'h01
`define NUM_EP_MAX 8'h1C

`endif

//--- design/adapter_endpoint_descriptor_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "adapter_desc_regs.vh"

// Function
// - Data-read endpoint descriptor is 7 bytes, type 5, then address.
// - Data-read attributes are 02H, bit 7 set when size adjustment is supported.
// - Data-read max packet size sits at offset 4; interval byte is 0.
// - Companion descriptors are 0AH bytes, type 17, burst size in byte 2.
// - Companion max sequence is kept within 2 to 32.
// - Data-read companion delay, air size, air interval, attributes all 00H.
// - Isochronous interface and endpoints exist only when isochronous is supported.
// - Isochronous interface is 9 bytes, type 4, number 1, alternate 0.
// - Isochronous interface endpoint count is kept within 1 to 28.
// - Isochronous interface class E0H, subclass 02H, protocol 03H.
// - Isochronous endpoints use attribute 01H; logical size equals air size.
// - Isochronous service interval matches air interval; interval byte reads 0.
// - Maximum OUT stream delay is reported; the host picks the real one.
// - OUT companion carries air max packet size at offset 6.
// - OUT companion interval byte is 00H; intervals 4 to 255 are accepted.
// - OUT companion attribute byte is 02H, scalable dynamic switching.
module adapter_endpoint_descriptor_rom #(
    parameter [7:0] READ_EP_ADDR = 8'h82,
    parameter [15:0] READ_MAX_PACKET = 16'h0200,
    parameter [7:0] READ_BURST = 8'h01,
    parameter [7:0] READ_SEQ = 8'h10,
    parameter SIZE_ADJUST = 1,
    parameter ISO_SUPPORTED = 1,
    parameter [7:0] NUM_ENDPOINTS = 8'h02,
    parameter [7:0] IF_STRING_INDEX = 8'h00,
    parameter [7:0] OUT_EP_ADDR = 8'h03,
    parameter [7:0] IN_EP_ADDR = 8'h84,
    parameter [15:0] OUT_MAX_PACKET = 16'h0400,
    parameter [15:0] IN_MAX_PACKET = 16'h0400,
    parameter [7:0] OUT_BURST = 8'h01,
    parameter [7:0] OUT_SEQ = 8'h10,
    parameter [15:0] OUT_STREAM_DELAY = 16'h0010
) (
    input wire clk_sys,
    input wire rstn,
    input wire req_valid,
    input wire [2:0] req_sel,
    input wire [15:0] req_length,
    output wire req_ready,
    output reg req_reject,
    output reg [7:0] data_byte,
    output reg data_valid,
    output reg data_last,
    input wire data_ready,
    output wire busy
);

    localparam ST_IDLE = 2'b01;
    localparam ST_SEND = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [2:0] cur_sel;
    reg [3:0] offset;
    reg [3:0] last_offset;
    reg [3:0] next_offset;
    wire [7:0] table_byte;

    function [7:0] clamp;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            if (v < lo)
                clamp = lo;
            else if (v > hi)
                clamp = hi;
            else
                clamp = v;
        end
    endfunction

    function [7:0] desc_len;
        input [2:0] s;
        begin
            case (s)
                `SEL_READ_COMP, `SEL_ISO_OUT_COMP: desc_len = `LEN_COMPANION;
                `SEL_ISO_IF: desc_len = `LEN_INTERFACE;
                default: desc_len = `LEN_ENDPOINT;
            endcase
        end
    endfunction

    function sel_present;
        input [2:0] s;
        begin
            if (s > `SEL_ISO_IN_EP)
                sel_present = 1'b0;
            else if (s >= `SEL_ISO_IF)
                sel_present = (ISO_SUPPORTED != 0);
            else
                sel_present = 1'b1;
        end
    endfunction

    wire [7:0] full_len = desc_len(req_sel);
    wire [3:0] send_len = (req_length < {8'h00, full_len}) ? req_length[3:0] : full_len[3:0];
    wire accept = req_valid && (state == ST_IDLE);
    wire good = sel_present(req_sel) && (send_len != 4'h0);
    wire advance = data_valid && data_ready;
    // offset moves with each load, so a byte taken on the same edge never repeats
    wire load_byte = (state == ST_SEND) && (!data_valid || (advance && !data_last));

    assign req_ready = (state == ST_IDLE);
    assign busy = (state == ST_SEND);

    desc_byte_table u_table (
        .sel(cur_sel),
        .offset(offset),
        .size_adjust(SIZE_ADJUST != 0),
        .read_ep_addr(READ_EP_ADDR),
        .read_max_packet(READ_MAX_PACKET),
        .read_burst(READ_BURST),
        .read_seq(clamp(READ_SEQ, `SEQ_MIN, `SEQ_MAX)),
        .num_endpoints(clamp(NUM_ENDPOINTS, `NUM_EP_MIN, `NUM_EP_MAX)),
        .if_string_index(IF_STRING_INDEX),
        .out_ep_addr(OUT_EP_ADDR),
        .in_ep_addr(IN_EP_ADDR),
        .out_max_packet(OUT_MAX_PACKET),
        .in_max_packet(IN_MAX_PACKET),
        .out_burst(OUT_BURST),
        .out_seq(clamp(OUT_SEQ, `SEQ_MIN, `SEQ_MAX)),
        .out_stream_delay(OUT_STREAM_DELAY),
        .byte_value(table_byte)
    );

    always @* begin
        next_state = state;
        next_offset = offset;
        case (state)
            ST_IDLE: begin
                if (accept && good) begin
                    next_state = ST_SEND;
                    next_offset = 4'h0;
                end
            end
            ST_SEND: begin
                if (advance && data_last)
                    next_state = ST_IDLE;
                if (load_byte)
                    next_offset = offset + 4'h1;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            state <= ST_IDLE;
            offset <= 4'h0;
            last_offset <= 4'h0;
            cur_sel <= `SEL_READ_EP;
            req_reject <= 1'b0;
        end else begin
            state <= next_state;
            offset <= next_offset;
            req_reject <= accept && !good;
            if (accept && good) begin
                cur_sel <= req_sel;
                last_offset <= send_len - 4'h1;
            end
        end
    end

    // registered byte stream, one byte per accepted beat
    always @(posedge clk_sys) begin
        if (!rstn) begin
            data_byte <= 8'h00;
            data_valid <= 1'b0;
            data_last <= 1'b0;
        end else if (load_byte) begin
            data_byte <= table_byte;
            data_valid <= 1'b1;
            data_last <= (offset == last_offset);
        end else if (advance) begin
            data_valid <= 1'b0;
            data_last <= 1'b0;
        end
    end

endmodule // adapter_endpoint_descriptor_rom
`default_nettype wire

//--- design/desc_byte_table.v
`timescale 1ns/1ps
`default_nettype none
`include "adapter_desc_regs.vh"

// combinational lookup of one descriptor byte
module desc_byte_table (
    input wire [2:0] sel,
    input wire [3:0] offset,
    input wire size_adjust,
    input wire [7:0] read_ep_addr,
    input wire [15:0] read_max_packet,
    input wire [7:0] read_burst,
    input wire [7:0] read_seq,
    input wire [7:0] num_endpoints,
    input wire [7:0] if_string_index,
    input wire [7:0] out_ep_addr,
    input wire [7:0] in_ep_addr,
    input wire [15:0] out_max_packet,
    input wire [15:0] in_max_packet,
    input wire [7:0] out_burst,
    input wire [7:0] out_seq,
    input wire [15:0] out_stream_delay,
    output reg [7:0] byte_value
);

    function [7:0] ep_byte;
        input [3:0] off;
        input [7:0] addr;
        input [7:0] attr;
        input [15:0] mps;
        begin
            case (off)
                4'h0: ep_byte = `LEN_ENDPOINT;
                4'h1: ep_byte = `DT_ENDPOINT;
                4'h2: ep_byte = addr;
                4'h3: ep_byte = attr;
                4'h4: ep_byte = mps[7:0];
                4'h5: ep_byte = mps[15:8];
                default: ep_byte = `RESERVED_BYTE;
            endcase
        end
    endfunction

    always @* begin
        byte_value = `RESERVED_BYTE;
        case (sel)
            `SEL_READ_EP: begin
                byte_value = ep_byte(offset, read_ep_addr,
                    `ATTR_BULK | {size_adjust, 7'h00}, read_max_packet);
            end
            `SEL_READ_COMP: begin
                case (offset)
                    4'h0: byte_value = `LEN_COMPANION;
                    4'h1: byte_value = `DT_COMPANION;
                    4'h2: byte_value = read_burst;
                    4'h3: byte_value = read_seq;
                    default: byte_value = `RESERVED_BYTE;
                endcase
            end
            `SEL_ISO_IF: begin
                case (offset)
                    4'h0: byte_value = `LEN_INTERFACE;
                    4'h1: byte_value = `DT_INTERFACE;
                    4'h2: byte_value = `IF_NUMBER;
                    4'h3: byte_value = `IF_ALT;
                    4'h4: byte_value = num_endpoints;
                    4'h5: byte_value = `IF_CLASS;
                    4'h6: byte_value = `IF_SUBCLASS;
                    4'h7: byte_value = `IF_PROTOCOL;
                    4'h8: byte_value = if_string_index;
                    default: byte_value = `RESERVED_BYTE;
                endcase
            end
            `SEL_ISO_OUT_EP: begin
                byte_value = ep_byte(offset, out_ep_addr, `ATTR_ISO, out_max_packet);
            end
            `SEL_ISO_OUT_COMP: begin
                case (offset)
                    4'h0: byte_value = `LEN_COMPANION;
                    4'h1: byte_value = `DT_COMPANION;
                    4'h2: byte_value = out_burst;
                    4'h3: byte_value = out_seq;
                    4'h4: byte_value = out_stream_delay[7:0];
                    4'h5: byte_value = out_stream_delay[15:8];
                    4'h6: byte_value = out_max_packet[7:0];
                    4'h7: byte_value = out_max_packet[15:8];
                    4'h8: byte_value = `RESERVED_BYTE;
                    4'h9: byte_value = `ATTR_DYN_SWITCH;
                    default: byte_value = `RESERVED_BYTE;
                endcase
            end
            `SEL_ISO_IN_EP: begin
                byte_value = ep_byte(offset, in_ep_addr, `ATTR_ISO, in_max_packet);
            end
            default: byte_value = `RESERVED_BYTE;
        endcase
    end

endmodule // desc_byte_table
`default_nettype wire

//--- testbench/adapter_endpoint_descriptor_rom_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adapter_endpoint_descriptor_rom_tb;
    `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected at %0t: %h", $time, a); end end
    logic clk_sys = 1'b0, rstn = 1'b0, req_valid = 1'b0, clr = 1'b0, slow = 1'b0;
    logic [2:0] req_sel = 3'h0;
    logic [15:0] req_length = 16'h0000;
    wire [1:0] rdy, rej, dv, dl, dr, bsy;
    wire [15:0] db;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    adapter_endpoint_descriptor_rom #(.READ_SEQ(8'h01), .NUM_ENDPOINTS(8'h1D))
        adapter_endpoint_descriptor_rom_i (.clk_sys(clk_sys), .rstn(rstn),
        .req_valid(req_valid), .req_sel(req_sel), .req_length(req_length), .req_ready(rdy[0]),
        .req_reject(rej[0]), .data_byte(db[7:0]), .data_valid(dv[0]), .data_last(dl[0]),
        .data_ready(dr[0]), .busy(bsy[0]));
    adapter_endpoint_descriptor_rom #(.READ_SEQ(8'h40), .SIZE_ADJUST(0), .ISO_SUPPORTED(0))
        adapter_endpoint_descriptor_rom_i2 (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
        .req_sel(req_sel), .req_length(req_length), .req_ready(rdy[1]), .req_reject(rej[1]),
        .data_byte(db[15:8]), .data_valid(dv[1]), .data_last(dl[1]), .data_ready(dr[1]), .busy(bsy[1]));
    host_sink host_sink_i (.clk_sys(clk_sys), .rstn(rstn), .clr(clr), .slow(slow), .data_valid(dv[0]),
        .data_byte(db[7:0]), .data_ready(dr[0]));
    host_sink host_sink_i2 (.clk_sys(clk_sys), .rstn(rstn), .clr(clr), .slow(slow), .data_valid(dv[1]),
        .data_byte(db[15:8]), .data_ready(dr[1]));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // expected bytes, offset 0 in the low byte
    function automatic logic [79:0] desc(input int i, input logic [2:0] s);
        case (s)
            3'h0: desc = {32'h0, 16'h0200, i ? 8'h02 : 8'h82, 8'h82, 8'h05, 8'h07};
            3'h1: desc = {48'h0, i ? 8'h20 : 8'h02, 8'h01, 8'h11, 8'h0A};
            3'h2: desc = {8'h00, 8'h00, 8'h03, 8'h02, 8'hE0, 8'h1C, 8'h00, 8'h01, 8'h04, 8'h09};
            3'h3: desc = {32'h0, 16'h0400, 8'h01, 8'h03, 8'h05, 8'h07};
            3'h4: desc = {8'h02, 8'h00, 16'h0400, 16'h0010, 8'h10, 8'h01, 8'h11, 8'h0A};
            default: desc = {32'h0, 16'h0400, 8'h01, 8'h84, 8'h05, 8'h07};
        endcase
    endfunction
    task automatic run(input logic [2:0] s, input logic [15:0] len, input logic slw);
        int n;
        int d;
        logic [79:0] e;
        @(posedge clk_sys);
        clr <= 1'b1;
        slow <= slw;
        @(posedge clk_sys);
        clr <= 1'b0;
        req_valid <= 1'b1;
        req_sel <= s;
        req_length <= len;
        @(negedge clk_sys);
        while (rdy !== 2'b11) @(negedge clk_sys);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        repeat (3) @(negedge clk_sys);
        while (bsy !== 2'b00) @(negedge clk_sys);
        for (int i = 0; i < 2; i++) begin
            e = desc(i, s);
            d = (s == 3'h1 || s == 3'h4) ? 10 : (s == 3'h2) ? 9 : 7;
            n = (len < d) ? len : d;
            if (len == 16'h0000 || s > 3'h5 || (i == 1 && s > 3'h1)) n = 0;
            `CHK(i ? host_sink_i2.cnt : host_sink_i.cnt, n)
            for (int k = 0; k < n; k++)
                `CHK(i ? host_sink_i2.got[k] : host_sink_i.got[k], e[8 * k +: 8])
        end
    endtask
    task automatic t_read_ep;
        run(3'h0, 16'h0007, 1'b0);
        run(3'h0, 16'h0001, 1'b1);
    endtask
    task automatic t_read_comp;
        run(3'h1, 16'hFFFF, 1'b1);
    endtask
    task automatic t_iso;
        for (int s = 2; s < 6; s++)
            run(s[2:0], 16'h0040, 1'b0);
    endtask
    task automatic t_trunc;
        run(3'h4, 16'h0003, 1'b0);
        run(3'h2, 16'h0009, 1'b1);
    endtask
    task automatic t_refuse;
        run(3'h6, 16'h0007, 1'b0);
        run(3'h7, 16'h0007, 1'b0);
        run(3'h0, 16'h0000, 1'b0);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            final_report;
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        `CHK({rdy, bsy, dv, dl, rej, db}, {2'b11, 24'h000000})
        rstn <= 1'b1;
        t_read_ep;
        t_read_comp;
        t_iso;
        t_trunc;
        t_refuse;
        final_report;
    end
endmodule // adapter_endpoint_descriptor_rom_tb
`default_nettype wire

//--- testbench/host_sink.sv
`timescale 1ns/1ps
`default_nettype none
// host side: takes one byte per handshake, then leaves one gap cycle, two when slow
module host_sink (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clr,
    input wire logic slow,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    output logic data_ready
);
    logic [7:0] got [0:15];
    int cnt;
    logic wait_c;
    always @(posedge clk_sys) begin
        if (!rstn || clr) begin
            data_ready <= 1'b0;
            cnt <= 0;
            wait_c <= 1'b0;
        end else if (data_ready && data_valid) begin
            got[cnt[3:0]] <= data_byte;
            cnt <= cnt + 1;
            data_ready <= 1'b0;
            wait_c <= 1'b0;
        end else if (data_valid) begin
            wait_c <= 1'b1;
            data_ready <= !slow || wait_c;
        end
    end
endmodule // host_sink
`default_nettype wire

//--- testbench/rom_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rom_sva (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic [2:0] req_sel,
    input wire logic [15:0] req_length,
    input wire logic req_ready,
    input wire logic req_reject,
    input wire logic [7:0] data_byte,
    input wire logic data_valid,
    input wire logic data_last,
    input wire logic data_ready,
    input wire logic busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence taken;
        req_valid && req_ready;
    endsequence
    sequence good(s);
        req_valid && req_ready && req_sel == s && req_length != 16'h0000;
    endsequence
    answer_time_a: assert property (taken |=> req_reject or (!req_reject ##1 data_valid))
        else $error("answer late");
    reject_pulse_a: assert property (req_reject |=> !req_reject) else $error("reject too long");
    reject_quiet_a: assert property (req_reject |-> !data_valid ##1 !data_valid)
        else $error("bytes after reject");
    bad_sel_a: assert property (req_valid && req_ready && req_sel > 3'h5 |=> req_reject)
        else $error("unknown selector taken");
    zero_len_a: assert property (req_valid && req_ready && req_length == 16'h0000 |=> req_reject)
        else $error("zero length taken");
    byte_stand_a: assert property (data_valid && !data_ready |=> data_valid && $stable(data_byte)
        && $stable(data_last)) else $error("byte dropped");
    first_ep_a: assert property (good(3'h0) |-> ##2 data_valid && data_byte == 8'h07)
        else $error("endpoint length byte");
    first_comp_a: assert property (good(3'h1) |-> ##2 data_valid && data_byte == 8'h0A)
        else $error("companion length byte");
    busy_gate_a: assert property (!busy |-> req_ready && !data_valid) else $error("byte while idle");
    last_done_a: assert property (data_valid && data_last && data_ready |=> !busy && !data_valid)
        else $error("stream not ended");
endmodule // rom_sva
bind adapter_endpoint_descriptor_rom rom_sva rom_sva_i (.clk_sys(clk_sys), .rstn(rstn),
    .req_valid(req_valid), .req_sel(req_sel), .req_length(req_length), .req_ready(req_ready),
    .req_reject(req_reject), .data_byte(data_byte), .data_valid(data_valid),
    .data_last(data_last), .data_ready(data_ready), .busy(busy));
`default_nettype wire
